// file: fcl_clkdiv.sv
`timescale 1ns/100ps
`default_nettype none
module fcl_clkdiv (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire logic [2:0] half_i,
    output logic sclk_o,
    output logic rise_o,
    output logic fall_o
);
    typedef struct packed {
        logic [2:0] cnt;
        logic sclk;
        logic rise;
        logic fall;
    } fcl_div_t;
    fcl_div_t d_reg;
    fcl_div_t d_next;

    always_comb begin
        d_next = d_reg;
        d_next.rise = 1'b0;
        d_next.fall = 1'b0;
        if (!run_i) begin
            d_next.cnt = 3'h0;
            d_next.sclk = 1'b0;
        end else if (d_reg.cnt >= 3'(half_i - 3'h1)) begin
            d_next.cnt = 3'h0;
            d_next.sclk = !d_reg.sclk;
            d_next.rise = !d_reg.sclk;
            d_next.fall = d_reg.sclk;
        end else begin
            d_next.cnt = 3'(d_reg.cnt + 3'h1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            d_reg <= '0;
        end else if (ce_i) begin
            d_reg <= d_next;
        end
    end

    assign sclk_o = d_reg.sclk;
    assign rise_o = d_reg.rise;
    assign fall_o = d_reg.fall;
endmodule : fcl_clkdiv
`default_nettype wire

// file: fcl_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module fcl_host_model (
    input wire logic mclk_i,
    output logic config_clock_o,
    output logic [15:0] par_data_o
);
    initial begin
        config_clock_o = 1'h0;
        par_data_o = 16'h0000;
    end
    // one 80 ns link cycle; clock only moves inside a transfer
    task automatic config_clock_cycle();
        repeat (4) @(posedge mclk_i);
        config_clock_o <= 1'h1;
        repeat (4) @(posedge mclk_i);
        config_clock_o <= 1'h0;
    endtask : config_clock_cycle
    // word held over the whole ratio group, so r-1 cycles follow the latch
    task automatic send_word(input logic [15:0] w, input int r);
        par_data_o <= w;
        repeat (r) config_clock_cycle();
    endtask : send_word
    // bus no longer meaningful: inverted so a stale word is never mistaken for data
    task automatic tail(input int n);
        par_data_o <= ~par_data_o;
        repeat (n) config_clock_cycle();
    endtask : tail
endmodule : fcl_host_model
`default_nettype wire

// file: fcl_load_port.sv
// What this block does
// - parallel words 8 or 16 bits, fixed per load
// - 8-bit: ratio 1, or 2 with decompression
// - 16-bit: ratio 1, 2 secure, 4 decompressing
// - finished device drives chain enable out low
// - enabled downstream device starts three mclk cycles later (two sync flops, then the state flop)
// - an error in load or done state pulls shared fault line low
// - shared lines make chain initialize together
// - chain enables tied low load concurrently
// - serial self-load supports 1 and 4 bits
// - restart low: reset, serial pins released
// - serial clock up to 50 MHz, four rate codes; the 50 and 100 MHz codes both give 50 MHz
// - serial starts at 12.5 MHz, options switch
// - serial starts 1-bit, options may select 4-bit
// - device masters serial load, writes cells
// - parallel word captured on config clock rising edge
// - load starts when restart and fault both high
// - on error drive fault low, complete stays low
// - full stream without error releases complete line
`timescale 1ns/100ps
`default_nettype none
module fcl_load_port (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic restart_request_line_n_i,
    input wire logic chain_enable_in_n_i,
    input wire logic [1:0] scheme_select_pins_i,
    input wire logic config_clock_i,
    input wire logic [15:0] par_data_i,
    input wire logic user_clock_pin_i,
    input wire logic [3:0] serial_data_i,
    input wire logic fault_status_line_i,
    input wire logic load_complete_line_i,
    input wire logic cfg_error_i,
    output fcl_pkg::fcl_od_t fault_status_line_o,
    output fcl_pkg::fcl_od_t load_complete_line_o,
    output fcl_pkg::fcl_od_t config_clock_o,
    output logic chain_enable_out_n_o,
    output fcl_pkg::fcl_cfg_out_t cfg_o,
    output logic user_mode_o
);
    import fcl_pkg::*;

    typedef struct packed {
        fcl_state_t state;
        logic wreq;
        logic [31:0] rdata;
        logic decomp;
        logic secure;
        logic [19:0] len;
        logic [1:0] scheme;
        logic [2:0] ratio;
        logic [2:0] grp;
        logic config_clock_q;
        logic usr_q;
        logic [19:0] cnt;
        logic [15:0] shreg;
        logic [4:0] bits;
        logic opt_done;
        logic x4;
        logic usr_src;
        logic [1:0] rate;
        logic [1:0] falls;
        logic own_err;
        fcl_od_t fault;
        fcl_od_t done;
        fcl_od_t sclk;
        logic ceo_n;
        fcl_cfg_out_t cfg;
        logic user;
    } fcl_core_t;

    fcl_core_t r_reg;
    fcl_core_t r_next;

    logic [27:0] pins_s;
    logic restart_s;
    logic ce_in_n_s;
    logic [1:0] sel_s;
    logic config_clock_s;
    logic [15:0] data_s;
    logic usr_s;
    logic [3:0] sdata_s;
    logic fault_s;
    logic done_s;
    logic div_run;
    logic div_sclk;
    logic div_fall;

    // every pin crosses two flops; data and its clock share the same latency
    fcl_sync #(.W(28)) u_sync (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .d_i({restart_request_line_n_i, chain_enable_in_n_i, scheme_select_pins_i,
              config_clock_i, par_data_i, user_clock_pin_i, serial_data_i,
              fault_status_line_i, load_complete_line_i}),
        .q_o(pins_s)
    );
    assign {restart_s, ce_in_n_s, sel_s, config_clock_s, data_s, usr_s, sdata_s, fault_s, done_s} = pins_s;

    assign div_run = (r_reg.state == ST_LOAD || r_reg.state == ST_DONE)
                     && r_reg.scheme == SCHEME_SERIAL && !r_reg.usr_src;

    fcl_clkdiv u_div (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .run_i(div_run),
        .half_i(fcl_half(r_reg.rate)),
        .sclk_o(div_sclk),
        .rise_o(),
        .fall_o(div_fall)
    );

    always_comb begin
        logic config_clock_rise;
        logic config_clock_fall;
        logic ser_fall;
        logic [4:0] nb;
        logic [15:0] nsh;
        logic [31:0] rd;
        fcl_status_t st;
        config_clock_rise = config_clock_s && !r_reg.config_clock_q;
        config_clock_fall = !config_clock_s && r_reg.config_clock_q;
        ser_fall = r_reg.usr_src ? (!usr_s && r_reg.usr_q) : div_fall;
        nb = 5'h0;
        nsh = 16'h0000;
        rd = 32'h0000_0000;
        st = '0;
        r_next = r_reg;
        r_next.config_clock_q = config_clock_s;
        r_next.usr_q = usr_s;
        r_next.cfg.valid = 1'b0;

        // bus slave: one wait cycle, answer on the second edge
        st.state = r_reg.state;
        st.scheme = r_reg.scheme;
        st.x4 = r_reg.x4;
        st.usr_src = r_reg.usr_src;
        st.rate = r_reg.rate;
        st.own_err = r_reg.own_err;
        if (avs_address_i == REG_CTRL) begin
            rd[CTRL_DECOMP_BIT] = r_reg.decomp;
            rd[CTRL_SECURE_BIT] = r_reg.secure;
        end else if (avs_address_i == REG_STATUS) begin
            rd = st;
        end else if (avs_address_i == REG_LEN) begin
            rd = {12'h000, r_reg.len};
        end else if (avs_address_i == REG_COUNT) begin
            rd = {12'h000, r_reg.cnt};
        end
        if ((avs_read_i || avs_write_i) && r_reg.wreq) begin
            r_next.wreq = 1'b0;
            r_next.rdata = avs_read_i ? rd : 32'h0000_0000;
        end else begin
            r_next.wreq = 1'b1;
        end
        if (avs_write_i && !r_reg.wreq) begin
            if (avs_address_i == REG_CTRL) begin
                r_next.decomp = avs_writedata_i[CTRL_DECOMP_BIT];
                r_next.secure = avs_writedata_i[CTRL_SECURE_BIT];
            end else if (avs_address_i == REG_LEN) begin
                r_next.len = avs_writedata_i[19:0];
            end
        end

        // serial clock pin follows the divider or the user clock
        r_next.sclk.o = r_reg.usr_src ? usr_s : div_sclk;
        r_next.sclk.oe = (r_reg.state == ST_LOAD || r_reg.state == ST_DONE)
                         && r_reg.scheme == SCHEME_SERIAL;

        case (r_reg.state)
            ST_RESET: begin
                r_next.fault = '{o: 1'b0, oe: 1'b1};
                if (restart_s) begin
                    r_next.state = ST_WAIT_FAULT;
                    r_next.fault = '{o: 1'b0, oe: 1'b0};
                end
            end
            ST_WAIT_FAULT: begin
                if (fault_s) begin
                    r_next.state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (!ce_in_n_s) begin
                    r_next.state = ST_LOAD;
                    r_next.scheme = sel_s;
                    r_next.grp = 3'h0;
                    r_next.cnt = 20'h0_0000;
                    r_next.bits = 5'h00;
                    r_next.opt_done = 1'b0;
                    r_next.x4 = 1'b0;
                    r_next.usr_src = 1'b0;
                    r_next.rate = RATE_12M5;
                    if (sel_s == SCHEME_PAR16) begin
                        r_next.ratio = r_reg.decomp ? RATIO_FOUR :
                                       r_reg.secure ? RATIO_TWO : RATIO_ONE;
                    end else begin
                        r_next.ratio = r_reg.decomp ? RATIO_TWO : RATIO_ONE;
                    end
                end
            end
            ST_LOAD: begin
                if (r_reg.scheme != SCHEME_SERIAL && config_clock_rise) begin
                    if (r_reg.grp == 3'h0) begin
                        r_next.cfg.word = (r_reg.scheme == SCHEME_PAR16) ? data_s
                                          : {8'h00, data_s[7:0]};
                        r_next.cfg.valid = 1'b1;
                        r_next.cnt = 20'(r_reg.cnt + 20'h0_0001);
                    end
                    // extra edges of a group go to decryption and decompression
                    r_next.grp = (r_reg.grp == 3'(r_reg.ratio - 3'h1)) ? 3'h0
                                 : 3'(r_reg.grp + 3'h1);
                end
                if (r_reg.scheme == SCHEME_SERIAL && ser_fall) begin
                    // limitation: data is sampled two mclk after the pin moved
                    if (r_reg.x4) begin
                        nsh = {r_reg.shreg[11:0], sdata_s};
                        nb = 5'(r_reg.bits + 5'h04);
                    end else begin
                        nsh = {r_reg.shreg[14:0], sdata_s[0]};
                        nb = 5'(r_reg.bits + 5'h01);
                    end
                    r_next.shreg = nsh;
                    r_next.bits = nb;
                    if (nb == SER_WORD_BITS) begin
                        r_next.bits = 5'h00;
                        if (!r_reg.opt_done) begin
                            r_next.opt_done = 1'b1;
                            r_next.rate = nsh[OPT_RATE_LSB +: 2];
                            r_next.usr_src = nsh[OPT_USR_BIT];
                            r_next.x4 = nsh[OPT_X4_BIT];
                        end else begin
                            r_next.cfg.word = nsh;
                            r_next.cfg.valid = 1'b1;
                            r_next.cnt = 20'(r_reg.cnt + 20'h0_0001);
                        end
                    end
                end
                if (r_next.cnt >= r_reg.len && r_next.cnt != 20'h0_0000) begin
                    r_next.state = ST_DONE;
                    r_next.done = '{o: 1'b0, oe: 1'b0};
                    r_next.ceo_n = 1'b0;
                    r_next.falls = 2'h0;
                end
            end
            ST_DONE: begin
                // shared complete line: whole chain waits for the last device
                if (done_s) begin
                    if (r_reg.scheme == SCHEME_SERIAL ? ser_fall : config_clock_fall) begin
                        r_next.falls = 2'(r_reg.falls + 2'h1);
                        if (2'(r_reg.falls + 2'h1) == INIT_FALLS) begin
                            r_next.state = ST_USER;
                            r_next.user = 1'b1;
                        end
                    end
                end
            end
            ST_USER: begin
                r_next.user = 1'b1;
            end
            ST_ERROR: begin
                r_next.done = '{o: 1'b0, oe: 1'b1};
            end
            default: begin
                r_next.state = ST_RESET;
            end
        endcase

        // errors stop the load for the whole chain
        if (r_reg.state == ST_LOAD || r_reg.state == ST_DONE) begin
            if (cfg_error_i) begin
                r_next.state = ST_ERROR;
                r_next.own_err = 1'b1;
                r_next.fault = '{o: 1'b0, oe: 1'b1};
                r_next.done = '{o: 1'b0, oe: 1'b1};
                r_next.ceo_n = 1'b1;
            end else if (!fault_s) begin
                r_next.state = ST_ERROR;
                r_next.done = '{o: 1'b0, oe: 1'b1};
                r_next.ceo_n = 1'b1;
            end
        end

        if (!restart_s) begin
            r_next.state = ST_RESET;
            r_next.fault = '{o: 1'b0, oe: 1'b1};
            r_next.done = '{o: 1'b0, oe: 1'b1};
            r_next.sclk = '{o: 1'b0, oe: 1'b0};
            r_next.ceo_n = 1'b1;
            r_next.user = 1'b0;
            r_next.own_err = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            r_reg <= '0;
            r_reg.state <= ST_RESET;
            r_reg.wreq <= 1'b1;
            r_reg.len <= LEN_RST;
            r_reg.ratio <= RATIO_ONE;
            r_reg.fault <= '{o: 1'b0, oe: 1'b1};
            r_reg.done <= '{o: 1'b0, oe: 1'b1};
            r_reg.ceo_n <= 1'b1;
        end else if (ce_i) begin
            r_reg <= r_next;
        end
    end

    assign avs_readdata_o = r_reg.rdata;
    assign avs_waitrequest_o = r_reg.wreq;
    assign fault_status_line_o = r_reg.fault;
    assign load_complete_line_o = r_reg.done;
    assign config_clock_o = r_reg.sclk;
    assign chain_enable_out_n_o = r_reg.ceo_n;
    assign cfg_o = r_reg.cfg;
    assign user_mode_o = r_reg.user;
endmodule : fcl_load_port
`default_nettype wire

// file: fcl_load_port_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module fcl_load_port_asserts (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic restart_request_line_n_i,
    input wire logic load_complete_line_i,
    input wire logic cfg_error_i,
    input wire fcl_pkg::fcl_od_t fault_status_line_o,
    input wire fcl_pkg::fcl_od_t load_complete_line_o,
    input wire fcl_pkg::fcl_od_t config_clock_o,
    input wire logic chain_enable_out_n_o,
    input wire fcl_pkg::fcl_cfg_out_t cfg_o,
    input wire logic user_mode_o
);
    import fcl_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    logic f_low;
    assign f_low = fault_status_line_o.oe && !fault_status_line_o.o;

    chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("bus answer not in one cycle");
    chk_bus_release: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    chk_word_pulse: assert property (cfg_o.valid |=> !cfg_o.valid)
        else $error("word valid longer than one cycle");
    chk_err_fault: assert property (cfg_error_i && $past(cfg_o.valid)
        && restart_request_line_n_i |=> f_low)
        else $error("load error did not pull fault line");
    chk_err_done: assert property (f_low
        |-> load_complete_line_o.oe && !load_complete_line_o.o)
        else $error("complete line not held low on fault");
    chk_chain_done: assert property (!chain_enable_out_n_o
        |-> !load_complete_line_o.oe) else $error("chain out low before completion");
    // chain out and the complete line move on the edge that delivers the last word
    chk_chain_fall: assert property ($fell(chain_enable_out_n_o)
        |-> cfg_o.valid && !load_complete_line_o.oe)
        else $error("chain out fell without the last word");
    chk_restart_pins: assert property (!restart_request_line_n_i [*4]
        |-> f_low && chain_enable_out_n_o && !user_mode_o && !config_clock_o.oe)
        else $error("restart low did not reset pins");
    chk_user_init: assert property ($rose(user_mode_o)
        |-> load_complete_line_i && !load_complete_line_o.oe)
        else $error("user mode without complete line high");
endmodule : fcl_load_port_asserts

bind fcl_load_port fcl_load_port_asserts i_fcl_load_port_asserts (.mclk_i, .srst_i,
    .avs_read_i, .avs_write_i, .avs_waitrequest_o, .restart_request_line_n_i,
    .load_complete_line_i, .cfg_error_i, .fault_status_line_o, .load_complete_line_o,
    .config_clock_o, .chain_enable_out_n_o, .cfg_o, .user_mode_o);
`default_nettype wire

// file: fcl_load_port_test.sv
`timescale 1ns/100ps
`default_nettype none
module fcl_load_port_test;
    import fcl_pkg::*;
    logic mclk_i, srst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [3:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic restart_request_line_n_i, chain_enable_in_n_i, config_clock_i, cfg_error_i;
    logic [1:0] scheme_select_pins_i;
    logic [15:0] par_data_i;
    logic fault_status_line_i, load_complete_line_i, chain_enable_out_n_o, user_mode_o;
    logic ext_pull;
    fcl_od_t fault_status_line_o, load_complete_line_o, config_clock_o;
    fcl_cfg_out_t cfg_o;
    logic [15:0] got_q[$];
    int n_errors = 0;
    int num_checks = 0;

    fcl_load_port i_fcl_load_port (.mclk_i, .srst_i, .ce_i(1'h1), .avs_address_i,
        .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
        .restart_request_line_n_i, .chain_enable_in_n_i, .scheme_select_pins_i,
        .config_clock_i, .par_data_i, .user_clock_pin_i(1'h0), .serial_data_i(4'h0),
        .fault_status_line_i, .load_complete_line_i, .cfg_error_i, .fault_status_line_o,
        .load_complete_line_o, .config_clock_o, .chain_enable_out_n_o, .cfg_o, .user_mode_o);
    fcl_host_model i_fcl_host_model (.mclk_i, .config_clock_o(config_clock_i),
        .par_data_o(par_data_i));

    // open-drain lines with pull-ups; ext_pull stands for another chained device
    assign fault_status_line_i = !(fault_status_line_o.oe && !fault_status_line_o.o) && !ext_pull;
    assign load_complete_line_i = !(load_complete_line_o.oe && !load_complete_line_o.o);

    always @(posedge mclk_i) begin
        if (cfg_o.valid === 1'h1) begin
            got_q.push_back(cfg_o.word);
        end
    end

    task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        // no cycle count assumed: only the watchdog ends a hung request
        do @(posedge mclk_i); while (avs_waitrequest_o !== 1'h0);
        q = avs_readdata_o;
        avs_read_i <= 1'h0;
        avs_write_i <= 1'h0;
    endtask : bus

    task automatic state_is(input logic [2:0] st);
        logic [31:0] q;
        bus(1'h0, REG_STATUS, 32'h0000_0000, q);
        chk("state", {17'h0_0000, st}, {17'h0_0000, q[2:0]});
    endtask : state_is

    task automatic restart();
        @(posedge mclk_i);
        restart_request_line_n_i <= 1'h0;
        chain_enable_in_n_i <= 1'h1;
        repeat (8) @(posedge mclk_i);
        chk("fault_pull", 20'h0_0001, fault_status_line_o.oe & !fault_status_line_o.o);
        chk("chain_out_n", 20'h0_0001, chain_enable_out_n_o);
        chk("sclk_oe", 20'h0_0000, config_clock_o.oe);
        restart_request_line_n_i <= 1'h1;
        repeat (8) @(posedge mclk_i);
    endtask : restart

    task automatic t_regs();
        logic [31:0] q;
        bus(1'h0, REG_LEN, 32'h0000_0000, q);
        chk("len_reset", LEN_RST, q[19:0]);
        bus(1'h0, 4'h2, 32'h0000_0000, q);
        chk("unmapped", 20'h0_0000, q[19:0]);
        bus(1'h1, REG_COUNT, 32'hFFFF_FFFF, q);
        bus(1'h0, REG_COUNT, 32'h0000_0000, q);
        chk("count_ro", 20'h0_0000, q[19:0]);
    endtask : t_regs

    task automatic t_load(input logic [1:0] sch, input logic [1:0] ctl, input int r);
        logic [31:0] q;
        logic [15:0] w;
        int i;
        scheme_select_pins_i <= sch;
        bus(1'h1, REG_LEN, 32'h0000_0003, q);
        bus(1'h1, REG_CTRL, {30'h0000_0000, ctl}, q);
        restart();
        state_is(3'h2);
        chain_enable_in_n_i <= 1'h0;
        // two sync flops, then the state flop
        repeat (3) @(posedge mclk_i);
        state_is(3'h3);
        got_q.delete();
        for (i = 0; i < 3; i++) begin
            i_fcl_host_model.send_word(16'hA5C3 + i[15:0], r);
        end
        i_fcl_host_model.tail(2);
        repeat (6) @(posedge mclk_i);
        chk("words", 20'h0_0003, 20'(got_q.size()));
        for (i = 0; i < 3; i++) begin
            w = 16'hA5C3 + i[15:0];
            chk("word", (sch == SCHEME_PAR8) ? {12'h000, w[7:0]} : {4'h0, w}, {4'h0, got_q[i]});
        end
        chk("complete_oe", 20'h0_0000, load_complete_line_o.oe);
        chk("chain_out_n", 20'h0_0000, chain_enable_out_n_o);
        chk("user_mode", 20'h0_0001, user_mode_o);
    endtask : t_load

    task automatic t_error();
        restart();
        chain_enable_in_n_i <= 1'h0;
        repeat (4) @(posedge mclk_i);
        fork
            i_fcl_host_model.send_word(16'h1234, 1);
            begin
                do @(posedge mclk_i); while (cfg_o.valid !== 1'h1);
                cfg_error_i <= 1'h1;
            end
        join
        // the error must stand across one edge, not be overwritten in its own time step
        @(posedge mclk_i);
        cfg_error_i <= 1'h0;
        repeat (2) @(posedge mclk_i);
        chk("err_fault", 20'h0_0001, fault_status_line_o.oe & !fault_status_line_o.o);
        chk("err_done", 20'h0_0001, load_complete_line_o.oe & !load_complete_line_o.o);
        state_is(3'h6);
    endtask : t_error

    task automatic t_fault();
        ext_pull <= 1'h1;
        restart();
        chain_enable_in_n_i <= 1'h0;
        state_is(3'h1);
        ext_pull <= 1'h0;
        repeat (8) @(posedge mclk_i);
        state_is(3'h3);
        ext_pull <= 1'h1;
        repeat (8) @(posedge mclk_i);
        state_is(3'h6);
        ext_pull <= 1'h0;
    endtask : t_fault

    task automatic t_serial();
        logic p;
        int n;
        scheme_select_pins_i <= SCHEME_SERIAL;
        restart();
        chain_enable_in_n_i <= 1'h0;
        repeat (20) @(posedge mclk_i);
        chk("sclk_oe", 20'h0_0001, config_clock_o.oe);
        n = 0;
        p = config_clock_o.o;
        repeat (64) begin
            @(posedge mclk_i);
            if (config_clock_o.o !== p) n++;
            p = config_clock_o.o;
        end
        chk("sclk_edges", 20'h0_0010, 20'(n));
    endtask : t_serial

    initial begin
        mclk_i = 1'h0;
        forever #5 mclk_i = ~mclk_i;
    end

    initial begin
        repeat (30000) @(posedge mclk_i);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        srst_i = 1'h1;
        {avs_read_i, avs_write_i, cfg_error_i, ext_pull} = 4'h0;
        avs_address_i = 4'h0;
        avs_writedata_i = 32'h0000_0000;
        restart_request_line_n_i = 1'h0;
        chain_enable_in_n_i = 1'h1;
        scheme_select_pins_i = SCHEME_PAR8;
        repeat (8) @(posedge mclk_i);
        srst_i <= 1'h0;
        t_regs();
        t_load(SCHEME_PAR8, 2'h0, 1);
        t_load(SCHEME_PAR8, 2'h2, 1);
        t_load(SCHEME_PAR8, 2'h1, 2);
        t_load(SCHEME_PAR8, 2'h3, 2);
        t_load(SCHEME_PAR16, 2'h0, 1);
        t_load(SCHEME_PAR16, 2'h2, 2);
        t_load(SCHEME_PAR16, 2'h1, 4);
        t_load(SCHEME_PAR16, 2'h3, 4);
        t_error();
        t_fault();
        t_serial();
        tally_and_finish();
    end
endmodule : fcl_load_port_test
`default_nettype wire

// file: fcl_pkg.sv
`default_nettype none
package fcl_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_LEN = 4'h8;
    localparam logic [3:0] REG_COUNT = 4'hC;
    localparam int CTRL_DECOMP_BIT = 0;
    localparam int CTRL_SECURE_BIT = 1;
    localparam logic [19:0] LEN_RST = 20'h0_0100;
    localparam logic [1:0] SCHEME_PAR8 = 2'h0;
    localparam logic [1:0] SCHEME_PAR16 = 2'h1;
    localparam logic [1:0] SCHEME_SERIAL = 2'h2;
    localparam logic [2:0] RATIO_ONE = 3'h1;
    localparam logic [2:0] RATIO_TWO = 3'h2;
    localparam logic [2:0] RATIO_FOUR = 3'h4;
    localparam logic [1:0] INIT_FALLS = 2'h2;
    localparam logic [4:0] SER_WORD_BITS = 5'h10;
    // serial option word, first word of the stream
    localparam int OPT_RATE_LSB = 0;
    localparam int OPT_USR_BIT = 2;
    localparam int OPT_X4_BIT = 3;
    localparam logic [1:0] RATE_12M5 = 2'h0;
    localparam int OSC_PERIOD_NS_12M5 = 80;
    localparam int OSC_PERIOD_NS_25M = 40;
    localparam int OSC_PERIOD_NS_50M = 20;
    localparam int OSC_PERIOD_NS_100M = 10;

    typedef enum logic [2:0] {
        ST_RESET, ST_WAIT_FAULT, ST_IDLE, ST_LOAD, ST_DONE, ST_USER, ST_ERROR
    } fcl_state_t;

    typedef struct packed {
        logic o;
        logic oe;
    } fcl_od_t;

    typedef struct packed {
        logic [15:0] word;
        logic valid;
    } fcl_cfg_out_t;

    typedef struct packed {
        logic [21:0] pad;
        logic own_err;
        logic [1:0] rate;
        logic usr_src;
        logic x4;
        logic [1:0] scheme;
        fcl_state_t state;
    } fcl_status_t;

    // half period of the self-driven clock in mclk cycles; rounds down, never below one
    function automatic logic [2:0] fcl_half(input logic [1:0] idx);
        int ns;
        int h;
        ns = (idx == 2'h0) ? OSC_PERIOD_NS_12M5 : (idx == 2'h1) ? OSC_PERIOD_NS_25M :
             (idx == 2'h2) ? OSC_PERIOD_NS_50M : OSC_PERIOD_NS_100M;
        h = ns / (2 * CLK_PERIOD_NS);
        if (h < 1) begin
            h = 1;
        end
        return h[2:0];
    endfunction : fcl_half
endpackage : fcl_pkg
`default_nettype wire

// file: fcl_sync.sv
`timescale 1ns/100ps
`default_nettype none
module fcl_sync #(
    parameter int W = 1
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } fcl_sync_t;
    fcl_sync_t s_reg;
    fcl_sync_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.meta = d_i;
        s_next.q = s_reg.meta;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            s_reg <= '0;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    assign q_o = s_reg.q;
endmodule : fcl_sync
`default_nettype wire
